//--- adc_calibration_control.sv
// Calibration sequencer with Avalon-MM register slave for the multi-channel converter
// How it works
// - Tuning-complete flag reads 1 after tuning ends, or when tuning is disabled and PLL hold bit is 0.
// - Run bit at 1 executes calibration; it resets to 1.
// - Run bit at 0 holds calibration logic in reset.
// - Clearing run bit also resets digital-core and serial-link clock dividers.
// - Bit 3 enables background offset calibration, only with background enabled.
// - Bit 2 enables foreground offset calibration, only with foreground set.
// - Bit 1 enables continuous background calibration; default off.
// - Calibration first resets values, then runs foreground if bit 0 set.
// - Offset reference 0 calibrates toward mid-code, zero offset.
// - Offset reference 1 matches primary offsets to the spare converter.
// - With tuning enabled, tuning starts when PLL hold bit written 0.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

module adc_calibration_control (
	input  wire logic                       i_clk,
	input  wire logic                       i_rstn,
	input  wire logic [calib_pkg::ADDR_W-1:0] i_avs_address,
	input  wire logic                       i_avs_read,
	input  wire logic                       i_avs_write,
	input  wire logic [31:0]                i_avs_writedata,
	input  wire logic [3:0]                 i_avs_byteenable,
	output logic      [31:0]                o_avs_readdata,
	output logic                            o_avs_waitrequest,
	output logic      [1:0]                 o_avs_response,
	output logic                            o_irq,
	output logic                            o_core_div_rstn,
	output logic                            o_link_div_rstn,
	output logic                            o_serial_link_enable,
	output logic                            o_pll_cal_hold,
	output logic      [6:0]                 o_oscillator_trim_code,
	output calib_pkg::cal_ctrl_t            o_cal_ctrl
);

	////////////////////////////////////////////////////////////////////////////
	// Register bus decode

	logic       run_reg;
	logic [3:0] mode_reg;
	logic [7:0] offset_cfg_reg;
	logic       pll_hold_reg;
	logic [7:0] tune_ctrl_reg;
	logic [6:0] trim_reg;
	logic [3:0] irq_status_reg;
	logic [3:0] irq_mask_reg;
	logic       link_en_reg;
	logic       rd_pending_reg;
	logic [31:0] rdata_reg;
	logic       rsp_err_reg;
	logic       tune_done_reg;

	wire        wr_lane0   = i_avs_write & i_avs_byteenable[0];
	wire        sel_run    = (i_avs_address == calib_pkg::OFS_RUN_CTRL);
	wire        sel_mode   = (i_avs_address == calib_pkg::OFS_MODE_CFG);
	wire        sel_ofs    = (i_avs_address == calib_pkg::OFS_OFFSET_CFG);
	wire        sel_hold   = (i_avs_address == calib_pkg::OFS_PLL_HOLD);
	wire        sel_tctl   = (i_avs_address == calib_pkg::OFS_TUNE_CTRL);
	wire        sel_trim   = (i_avs_address == calib_pkg::OFS_TRIM);
	wire        sel_tstat  = (i_avs_address == calib_pkg::OFS_TUNE_STATUS);
	wire        sel_istat  = (i_avs_address == calib_pkg::OFS_IRQ_STATUS);
	wire        sel_imask  = (i_avs_address == calib_pkg::OFS_IRQ_MASK);
	wire        sel_link   = (i_avs_address == calib_pkg::OFS_LINK_CTRL);
	wire        sel_any    = sel_run | sel_mode | sel_ofs | sel_hold | sel_tctl | sel_trim
	                       | sel_tstat | sel_istat | sel_imask | sel_link;
	wire [7:0]  wbyte      = i_avs_writedata[7:0];
	wire        tune_en    = tune_ctrl_reg[0];
	wire        tuning     = tune_en & ~pll_hold_reg & ~tune_done_reg;

	// Writes complete in one cycle; reads take one wait state for registered data
	assign o_avs_waitrequest = i_avs_read & ~rd_pending_reg;
	assign o_avs_readdata    = rdata_reg;
	assign o_avs_response    = rsp_err_reg ? 2'h2 : 2'h0;

	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (sel_tstat) rd_mux = {7'h00, tune_done_reg};
		if (sel_run)   rd_mux = {7'h00, run_reg};
		if (sel_mode)  rd_mux = {4'h0, mode_reg};
		if (sel_ofs)   rd_mux = offset_cfg_reg;
		if (sel_hold)  rd_mux = {7'h00, pll_hold_reg};
		if (sel_tctl)  rd_mux = tune_ctrl_reg;
		if (sel_trim)  rd_mux = {1'b0, trim_reg};
		if (sel_istat) rd_mux = {4'h0, irq_status_reg};
		if (sel_imask) rd_mux = {4'h0, irq_mask_reg};
		if (sel_link)  rd_mux = {7'h00, link_en_reg};
	end

	wire rd_take = i_avs_read & ~rd_pending_reg;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_pending_reg <= 1'b0;
		end else begin
			rd_pending_reg <= rd_take;
		end
	end

	// Data is captured once so it stands through the accepting cycle
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd_take) begin
			rdata_reg <= {24'h00_0000, rd_mux};
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rsp_err_reg <= 1'b0;
		end else if (rd_take | i_avs_write) begin
			rsp_err_reg <= ~sel_any;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers

	// Trim writes during tuning are dropped to protect the engine
	wire trim_wr_ok = wr_lane0 & sel_trim & ~tuning;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_reg <= calib_pkg::RST_RUN_CTRL[0];
		end else if (wr_lane0 & sel_run) begin
			run_reg <= wbyte[0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_reg <= calib_pkg::RST_MODE_CFG[3:0];
		end else if (wr_lane0 & sel_mode) begin
			mode_reg <= wbyte[3:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			offset_cfg_reg <= calib_pkg::RST_OFFSET_CFG;
		end else if (wr_lane0 & sel_ofs) begin
			offset_cfg_reg <= wbyte;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pll_hold_reg <= calib_pkg::RST_PLL_HOLD[0];
		end else if (wr_lane0 & sel_hold) begin
			pll_hold_reg <= wbyte[0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tune_ctrl_reg <= calib_pkg::RST_TUNE_CTRL;
		end else if (wr_lane0 & sel_tctl) begin
			tune_ctrl_reg <= wbyte;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_mask_reg <= calib_pkg::RST_IRQ_MASK;
		end else if (wr_lane0 & sel_imask) begin
			irq_mask_reg <= wbyte[3:0];
		end
	end

	// Link cannot be enabled while calibration is held
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			link_en_reg <= 1'b0;
		end else if (wr_lane0 & sel_link) begin
			link_en_reg <= wbyte[0] & run_reg;
		end else if (!run_reg) begin
			link_en_reg <= 1'b0;
		end
	end

	assign o_serial_link_enable = link_en_reg;
	assign o_pll_cal_hold       = pll_hold_reg;
	assign o_core_div_rstn      = run_reg;
	assign o_link_div_rstn      = run_reg;

	////////////////////////////////////////////////////////////////////////////
	// Oscillator tuning engine

	logic [calib_pkg::CNT_W-1:0] tune_cnt_reg;
	wire tune_finish = tuning & (tune_cnt_reg == calib_pkg::CNT_W'(calib_pkg::TUNE_CYC - 1));

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tune_cnt_reg  <= '0;
			tune_done_reg <= 1'b0;
		end else begin
			if (pll_hold_reg) begin
				tune_cnt_reg  <= '0;
				tune_done_reg <= 1'b0;
			end else if (!tune_en) begin
				tune_done_reg <= 1'b1;
			end else if (tuning) begin
				tune_cnt_reg <= tune_cnt_reg + 1'b1;
				if (tune_finish) tune_done_reg <= 1'b1;
			end
		end
	end

	// Software write and engine stepping never overlap: writes are refused while tuning
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			trim_reg <= calib_pkg::RST_TRIM[6:0];
		end else if (trim_wr_ok) begin
			trim_reg <= wbyte[6:0];
		end else if (tuning) begin
			trim_reg <= tune_cnt_reg[7:1];
		end
	end

	assign o_oscillator_trim_code = trim_reg;

	////////////////////////////////////////////////////////////////////////////
	// Calibration sequencer

	typedef enum logic [2:0] {ST_IDLE, ST_RESET, ST_FG, ST_FG_OS, ST_BG} cal_state_t;
	cal_state_t                  state_reg;
	cal_state_t                  state_next;
	logic [calib_pkg::CNT_W-1:0] cnt_reg;
	logic                        fg_done_reg;

	wire fg_en  = mode_reg[calib_pkg::BIT_FG];
	wire bg_en  = mode_reg[calib_pkg::BIT_BG];
	wire fos_en = mode_reg[calib_pkg::BIT_FG_OS] & fg_en;
	wire bos_en = mode_reg[calib_pkg::BIT_BG_OS] & bg_en;
	wire rst_end = (cnt_reg == calib_pkg::CNT_W'(calib_pkg::RESET_STEP_CYC - 1));
	wire fg_end  = (cnt_reg == calib_pkg::CNT_W'(calib_pkg::FG_CAL_CYC - 1));
	wire os_end  = (cnt_reg == calib_pkg::CNT_W'(calib_pkg::OS_CAL_CYC - 1));
	wire after_fg = bg_en ? 1'b1 : 1'b0;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:  state_next = ST_RESET;
			ST_RESET: if (rst_end) state_next = fg_en ? ST_FG : (after_fg ? ST_BG : ST_IDLE);
			ST_FG:    if (fg_end) state_next = fos_en ? ST_FG_OS : (after_fg ? ST_BG : ST_IDLE);
			ST_FG_OS: if (os_end) state_next = after_fg ? ST_BG : ST_IDLE;
			ST_BG:    if (!bg_en) state_next = ST_IDLE;
			default:  state_next = ST_IDLE;
		endcase
		// Finished sequence parks in idle until the next run cycle
		if (state_reg == ST_IDLE && fg_done_reg) state_next = ST_IDLE;
	end

	wire fg_finish = (state_next == ST_BG) | ((state_reg != ST_IDLE) & (state_next == ST_IDLE));

	// Run bit low acts as a synchronous reset of the whole sequencer
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ST_IDLE;
		end else if (!run_reg) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Step counter restarts on every state change
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_reg <= '0;
		end else if (!run_reg || state_next != state_reg) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fg_done_reg <= 1'b0;
		end else if (!run_reg) begin
			fg_done_reg <= 1'b0;
		end else if (fg_finish) begin
			fg_done_reg <= 1'b1;
		end
	end

	always_comb begin
		o_cal_ctrl                  = '0;
		o_cal_ctrl.cal_values_reset = (state_reg == ST_RESET) | ~run_reg;
		o_cal_ctrl.fg_cal_active    = (state_reg == ST_FG);
		o_cal_ctrl.fg_offset_active = (state_reg == ST_FG_OS);
		o_cal_ctrl.bg_cal_active    = (state_reg == ST_BG);
		o_cal_ctrl.bg_offset_active = (state_reg == ST_BG) & bos_en;
		o_cal_ctrl.offset_to_spare  = offset_cfg_reg[calib_pkg::BIT_OFFSET_REFERENCE_SELECT];
		o_cal_ctrl.fg_done          = fg_done_reg;
	end
	// offset_to_spare low selects the mid-code target

	////////////////////////////////////////////////////////////////////////////
	// Interrupts

	logic tune_done_d_reg;
	logic fg_done_d_reg;
	logic fos_d_reg;
	logic run_d_reg;

	wire [3:0] ev = {run_d_reg & ~run_reg & ~fg_done_reg & (state_reg != ST_IDLE),
	                 fos_d_reg & (state_reg != ST_FG_OS) & run_reg,
	                 fg_done_reg & ~fg_done_d_reg,
	                 tune_done_reg & ~tune_done_d_reg};
	wire [3:0] clr = (wr_lane0 & sel_istat) ? wbyte[3:0] : 4'h0;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_status_reg <= 4'h0;
		end else begin
			// Set wins over a simultaneous clear
			irq_status_reg <= (irq_status_reg & ~clr) | ev;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tune_done_d_reg <= 1'b0;
			fg_done_d_reg   <= 1'b0;
			fos_d_reg       <= 1'b0;
			run_d_reg       <= 1'b0;
		end else begin
			tune_done_d_reg <= tune_done_reg;
			fg_done_d_reg   <= fg_done_reg;
			fos_d_reg       <= (state_reg == ST_FG_OS);
			run_d_reg       <= run_reg;
		end
	end

	assign o_irq = |(irq_status_reg & irq_mask_reg);

endmodule : adc_calibration_control

`default_nettype wire

//--- calib_monitor.sv
// Port-level assertions for the calibration controller
`timescale 1ns/10ps
`default_nettype none
module calib_monitor (
	input  wire logic                         i_clk,
	input  wire logic                         i_rstn,
	input  wire logic [calib_pkg::ADDR_W-1:0] i_avs_address,
	input  wire logic                         i_avs_write,
	input  wire logic [31:0]                  i_avs_writedata,
	input  wire logic [3:0]                   i_avs_byteenable,
	input  wire logic                         o_irq,
	input  wire logic                         o_core_div_rstn,
	input  wire logic                         o_link_div_rstn,
	input  wire logic                         o_serial_link_enable,
	input  wire calib_pkg::cal_ctrl_t         o_cal_ctrl
);
	// Shadow copies: writes never wait, so a write strobe is a taken write
	logic [7:0] mode_reg;
	logic [7:0] ofs_reg;
	logic [3:0] mask_reg;
	wire        wr_lane0 = i_avs_write && i_avs_byteenable[0];
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_reg <= calib_pkg::RST_MODE_CFG;
			ofs_reg  <= calib_pkg::RST_OFFSET_CFG;
			mask_reg <= calib_pkg::RST_IRQ_MASK;
		end else if (wr_lane0) begin
			if (i_avs_address == calib_pkg::OFS_MODE_CFG) mode_reg <= i_avs_writedata[7:0];
			if (i_avs_address == calib_pkg::OFS_OFFSET_CFG) ofs_reg <= i_avs_writedata[7:0];
			if (i_avs_address == calib_pkg::OFS_IRQ_MASK) mask_reg <= i_avs_writedata[3:0];
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	////////////////////////////////////////////////////////////////
	property p_div_pair; o_core_div_rstn == o_link_div_rstn; endproperty
	a_div_pair: assert property (p_div_pair) else $error("divider resets differ");
	property p_link_off; !o_core_div_rstn ##1 !o_core_div_rstn |-> !o_serial_link_enable; endproperty
	a_link_off: assert property (p_link_off) else $error("link enabled while run clear");
	property p_held;
		!o_core_div_rstn ##1 !o_core_div_rstn |-> o_cal_ctrl.cal_values_reset && !o_cal_ctrl.fg_cal_active
			&& !o_cal_ctrl.fg_done;
	endproperty
	a_held: assert property (p_held) else $error("sequencer active while run clear");
	property p_fg_start; $rose(o_core_div_rstn) && mode_reg[0] |-> ##[2:12] o_cal_ctrl.fg_cal_active; endproperty
	a_fg_start: assert property (p_fg_start) else $error("foreground did not start");
	property p_reset_first; $rose(o_cal_ctrl.fg_cal_active) |-> $past(o_cal_ctrl.cal_values_reset); endproperty
	a_reset_first: assert property (p_reset_first) else $error("foreground without value reset");
	property p_bg; o_cal_ctrl.bg_cal_active |-> mode_reg[calib_pkg::BIT_BG]; endproperty
	a_bg: assert property (p_bg) else $error("background active while disabled");
	property p_bgos; o_cal_ctrl.bg_offset_active |-> mode_reg[3] && mode_reg[1]; endproperty
	a_bgos: assert property (p_bgos) else $error("background offset active illegally");
	property p_fgos; o_cal_ctrl.fg_offset_active |-> mode_reg[2] && mode_reg[0]; endproperty
	a_fgos: assert property (p_fgos) else $error("foreground offset active illegally");
	property p_spare; o_cal_ctrl.offset_to_spare |-> ofs_reg[calib_pkg::BIT_OFFSET_REFERENCE_SELECT]; endproperty
	a_spare: assert property (p_spare) else $error("spare reference without select");
	property p_irq; o_irq |-> mask_reg != 4'h0; endproperty
	a_irq: assert property (p_irq) else $error("interrupt with all sources masked");
	property p_restart; $rose(o_core_div_rstn) |-> !o_cal_ctrl.fg_done; endproperty
	a_restart: assert property (p_restart) else $error("done kept across restart");
endmodule : calib_monitor
bind adc_calibration_control calib_monitor u_mon (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
	.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_irq(o_irq), .o_core_div_rstn(o_core_div_rstn), .o_link_div_rstn(o_link_div_rstn),
	.o_serial_link_enable(o_serial_link_enable), .o_cal_ctrl(o_cal_ctrl));
`default_nettype wire

//--- calib_pkg.sv
// Package with register map, field positions and types for the calibration controller
package calib_pkg;

	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFS_TUNE_STATUS = 8'h5E;
	localparam logic [7:0]  OFS_RUN_CTRL    = 8'h61;
	localparam logic [7:0]  OFS_MODE_CFG    = 8'h62;
	localparam logic [7:0]  OFS_OFFSET_CFG  = 8'h65;
	localparam logic [7:0]  OFS_PLL_HOLD    = 8'h5C;
	localparam logic [7:0]  OFS_TUNE_CTRL   = 8'h5D;
	localparam logic [7:0]  OFS_TRIM        = 8'h5F;
	localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h70;
	localparam logic [7:0]  OFS_IRQ_MASK    = 8'h71;
	localparam logic [7:0]  OFS_LINK_CTRL   = 8'h72;

	localparam logic [7:0]  RST_RUN_CTRL    = 8'h01;
	localparam logic [7:0]  RST_MODE_CFG    = 8'h01;
	localparam logic [7:0]  RST_OFFSET_CFG  = 8'h01;
	localparam logic [7:0]  RST_PLL_HOLD    = 8'h00;
	localparam logic [7:0]  RST_TUNE_CTRL   = 8'h00;
	localparam logic [7:0]  RST_TRIM        = 8'h00;
	localparam logic [3:0]  RST_IRQ_MASK    = 4'h0;

	localparam int          BIT_FG          = 0;
	localparam int          BIT_BG          = 1;
	localparam int          BIT_FG_OS       = 2;
	localparam int          BIT_BG_OS       = 3;
	localparam int          BIT_OFFSET_REFERENCE_SELECT       = 2;

	localparam int          IRQ_TUNE_DONE   = 0;
	localparam int          IRQ_FG_DONE     = 1;
	localparam int          IRQ_FG_OS_DONE  = 2;
	localparam int          IRQ_ABORT       = 3;

	localparam int          RESET_STEP_CYC  = 4;
	localparam int          FG_CAL_CYC      = 64;
	localparam int          OS_CAL_CYC      = 32;
	localparam int          TUNE_CYC        = 128;
	localparam int          CNT_W           = 8;

	typedef struct packed {
		logic bg_offset_cal_enable;
		logic fg_offset_cal_enable;
		logic background_cal_enable;
		logic foreground_cal_run;
	} mode_cfg_t;

	typedef struct packed {
		logic       cal_values_reset;
		logic       fg_cal_active;
		logic       fg_offset_active;
		logic       bg_cal_active;
		logic       bg_offset_active;
		logic       offset_to_spare;
		logic       fg_done;
	} cal_ctrl_t;

endpackage : calib_pkg

//--- tb.sv
// Self-checking bench for the calibration controller
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic                 i_clk;
	logic                 i_rstn;
	logic [7:0]           i_avs_address;
	logic                 i_avs_read;
	logic                 i_avs_write;
	logic [31:0]          i_avs_writedata;
	logic [3:0]           i_avs_byteenable;
	logic [31:0]          o_avs_readdata;
	logic                 o_avs_waitrequest;
	logic                 o_irq;
	logic                 o_core_div_rstn;
	logic                 o_link_div_rstn;
	logic                 o_serial_link_enable;
	logic [6:0]           o_oscillator_trim_code;
	logic [1:0]           o_avs_response;
	logic                 o_pll_cal_hold;
	calib_pkg::cal_ctrl_t o_cal_ctrl;
	logic                 wq_s;
	logic [7:0]           rd_s;
	logic [7:0]           got;
	int                   err_total;
	int                   comparisons;
	adc_calibration_control uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response), .o_irq(o_irq),
		.o_core_div_rstn(o_core_div_rstn), .o_link_div_rstn(o_link_div_rstn),
		.o_serial_link_enable(o_serial_link_enable), .o_pll_cal_hold(o_pll_cal_hold),
		.o_oscillator_trim_code(o_oscillator_trim_code), .o_cal_ctrl(o_cal_ctrl));
	always #20 i_clk = ~i_clk;
	// Settled bus answer, taken mid-cycle so the edge decision never races
	always @(negedge i_clk) begin
		wq_s = o_avs_waitrequest;
		rd_s = o_avs_readdata[7:0];
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_avs_address   <= a;
		i_avs_writedata <= {24'h000000, d};
		i_avs_write     <= 1'b1;
		do @(posedge i_clk); while (wq_s);
		i_avs_write <= 1'b0;
		@(posedge i_clk);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		i_avs_address <= a;
		i_avs_read    <= 1'b1;
		do @(posedge i_clk); while (wq_s);
		got = rd_s;
		i_avs_read <= 1'b0;
		@(posedge i_clk);
		chk("register", got, exp);
	endtask : rc
	task automatic close_out();
		if (err_total == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////
	task automatic t_power_up();
		int n;
		chk("div rstn", o_core_div_rstn, 1);
		for (n = 0; n < 200 && o_cal_ctrl.fg_done !== 1'b1; n++) @(posedge i_clk);
		chk("fg done", o_cal_ctrl.fg_done, 1);
		rc(calib_pkg::OFS_RUN_CTRL, calib_pkg::RST_RUN_CTRL);
		rc(calib_pkg::OFS_MODE_CFG, calib_pkg::RST_MODE_CFG);
		rc(calib_pkg::OFS_OFFSET_CFG, calib_pkg::RST_OFFSET_CFG);
		rc(calib_pkg::OFS_TUNE_STATUS, 8'h01);
		chk("response ok", o_avs_response, 2'h0);
		rc(8'h40, 8'h00);
		chk("response unmapped", o_avs_response, 2'h2);
	endtask : t_power_up
	task automatic t_modes();
		logic [7:0] modes [6] = '{8'h00, 8'h01, 8'h05, 8'h04, 8'h02, 8'h0B};
		logic [7:0] m;
		int         nf;
		int         no;
		foreach (modes[i]) begin
			m = modes[i];
			nf = 0;
			no = 0;
			wr(calib_pkg::OFS_RUN_CTRL, 8'h00);
			wr(calib_pkg::OFS_LINK_CTRL, 8'h01);
			rc(calib_pkg::OFS_LINK_CTRL, 8'h00);
			chk("held", {o_link_div_rstn, o_cal_ctrl.cal_values_reset}, 2'b01);
			wr(calib_pkg::OFS_MODE_CFG, m);
			wr(calib_pkg::OFS_OFFSET_CFG, m[1] ? 8'h05 : 8'h01);
			wr(calib_pkg::OFS_RUN_CTRL, 8'h01);
			repeat (150) begin
				@(posedge i_clk);
				nf += o_cal_ctrl.fg_cal_active;
				no += o_cal_ctrl.fg_offset_active;
			end
			chk("fg cycles", nf, m[0] ? calib_pkg::FG_CAL_CYC : 0);
			chk("fg offset cycles", no, (m[0] & m[2]) ? calib_pkg::OS_CAL_CYC : 0);
			chk("bg", o_cal_ctrl.bg_cal_active, m[1]);
			chk("bg offset", o_cal_ctrl.bg_offset_active, m[1] & m[3]);
			chk("spare ref", o_cal_ctrl.offset_to_spare, m[1]);
			if (!m[1]) chk("fg done", o_cal_ctrl.fg_done, 1);
		end
	endtask : t_modes
	task automatic t_irq_abort();
		wr(calib_pkg::OFS_RUN_CTRL, 8'h00);
		wr(calib_pkg::OFS_MODE_CFG, 8'h01);
		wr(calib_pkg::OFS_RUN_CTRL, 8'h01);
		wr(calib_pkg::OFS_LINK_CTRL, 8'h01);
		rc(calib_pkg::OFS_LINK_CTRL, 8'h01);
		wr(calib_pkg::OFS_LINK_CTRL, 8'h00);
		wr(calib_pkg::OFS_IRQ_STATUS, 8'h0F);
		wr(calib_pkg::OFS_IRQ_MASK, 8'h08);
		chk("irq idle", o_irq, 0);
		wr(calib_pkg::OFS_RUN_CTRL, 8'h00);
		@(posedge i_clk);
		chk("irq abort", o_irq, 1);
		rc(calib_pkg::OFS_IRQ_STATUS, 8'h08);
		wr(calib_pkg::OFS_IRQ_MASK, 8'h00);
		@(posedge i_clk);
		chk("irq masked", o_irq, 0);
		wr(calib_pkg::OFS_IRQ_MASK, 8'h08);
		@(posedge i_clk);
		chk("irq unmasked", o_irq, 1);
		wr(calib_pkg::OFS_IRQ_STATUS, 8'h08);
		@(posedge i_clk);
		chk("irq cleared", o_irq, 0);
	endtask : t_irq_abort
	task automatic t_tune();
		wr(calib_pkg::OFS_PLL_HOLD, 8'h01);
		chk("pll hold set", o_pll_cal_hold, 1);
		wr(calib_pkg::OFS_TUNE_CTRL, 8'h01);
		rc(calib_pkg::OFS_TUNE_STATUS, 8'h00);
		wr(calib_pkg::OFS_PLL_HOLD, 8'h00);
		rc(calib_pkg::OFS_TUNE_STATUS, 8'h00);
		chk("pll hold clear", o_pll_cal_hold, 0);
		repeat (calib_pkg::TUNE_CYC + 8) @(posedge i_clk);
		rc(calib_pkg::OFS_TUNE_STATUS, 8'h01);
		wr(calib_pkg::OFS_TRIM, 8'h55);
		chk("trim", o_oscillator_trim_code, 7'h55);
	endtask : t_tune
	////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		i_rstn = 1'b0;
		i_avs_address = 8'h00;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h00000000;
		i_avs_byteenable = 4'hF;
		err_total = 0;
		comparisons = 0;
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		t_power_up();
		t_modes();
		t_irq_abort();
		t_tune();
		close_out();
	end
	// Whole run needs under two thousand cycles; far beyond that means a hang
	initial begin
		repeat (30000) @(posedge i_clk);
		err_total++;
		close_out();
	end
endmodule : tb
`default_nettype wire
